/* common/spm_regs.svh */
/*
  Register map, field positions, reset values and timing counts of the serial
  pin multiplexer. Assumes a 32-bit classic Wishbone slave with byte addresses.
*/
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH

// byte offsets
`define SPM_ADDR_MODE      8'h00
`define SPM_ADDR_CLKCTL    8'h04
`define SPM_ADDR_SLOTMAP   8'h08
`define SPM_ADDR_PORTSEL   8'h0C
`define SPM_ADDR_EVENT     8'h10
`define SPM_ADDR_STATUS    8'h14

// mode register fields
`define SPM_MODE_SEL_LSB   0
`define SPM_MODE_TXD_OD    2
`define SPM_MODE_INT_BRG   3
`define SPM_MODE_CD_AUTO   4
`define SPM_MODE_CTS_AUTO  5
`define SPM_MODE_CTS_ABORT 6
`define SPM_MODE_CD_SYNC   7
`define SPM_MODE_RESET     32'h0000_0030

// clock control register fields
`define SPM_CLK_BRG_DIS    11
`define SPM_CLK_RCLK_DIS   12
`define SPM_CLK_TCLK_DIS   13
`define SPM_CLKCTL_RESET   32'h0000_0000

// slot map: three 2-bit channel indexes, then strobe masks
`define SPM_SLOT_W         2
`define SPM_SLOT_NONE      2'h3
`define SPM_DATA_STROBE_OUTPUT_1_LSB       8
`define SPM_DATA_STROBE_OUTPUT_2_LSB       10
`define SPM_SLOTMAP_RESET  32'h0000_0024

// port select: port 2 pio bits, port 3 pio bits, scp enable
`define SPM_P3_PIO_LSB     8
`define SPM_SCP_EN         16
`define SPM_PORTSEL_RESET  32'h0000_0000

// event and status bits, pcm request pin positions
`define SPM_EV_CD          0
`define SPM_EV_CTS         1
`define SPM_P2_RTS_BIT     5
`define SPM_P3_RTS_BIT     6

// clock edges a changed line must hold before it counts
`define SPM_HOLD_EDGES     2'h2

`endif

/* common/spm_pkg.sv */
/*
  Types of the serial pin multiplexer. Assumes nothing beyond the tool.
*/
package spm_pkg;
  // serial interface modes
  typedef enum logic [1:0] {
    SPM_NON_MULTIPLEXED_MODE = 2'h0,
    SPM_FIRST_ISDN_BUS_MODE  = 2'h1,
    SPM_SECOND_ISDN_BUS_MODE = 2'h2,
    SPM_PCM_MODE             = 2'h3
  } spm_mode_t;

  typedef logic [2:0] spm_chan_t;
endpackage

/* logic/spm_pin_mux.sv */
/*
  Pin-function multiplexer of the physical layer serial interface: the shared
  layer-1 port, the port 2 / port 3 pin groups, clock pin enables, PCM sync
  decoding and line change events, with a classic Wishbone register slave.
  Assumes the serial channels, baud generator and parallel port sit on clk.
*/
// Added by the designer: the placing of the registers and the Wishbone register port.
`include "spm_regs.svh"

// Notes on behaviour
// - mux modes share port one with channels
// - port two/three pins pick channel or parallel
// - one plain mode, three multiplexed modes
// - receive pin feeds channel one or layer1
// - plain mode transmit pin may be open-drain
// - push-pull transmit in isdn1, tristate pcm, open-drain isdn2
// - receive clock direction follows clock source
// - receive clock disable bit floats pin
// - transmit clock pin function per mode
// - transmit clock disable bit floats pin
// - internal generator drives both clock pins, plain mode
// - pcm sync code selects slot or mute
// - slots map to channels by register
// - strobes mark b1/b2 times per masks
// - carrier pin function per mode
// - carrier change held two edges sets event, plain mode
// - carrier pin becomes interrupt when not automatic
// - carrier level readable in status
// - carrier pin gives external sync, plain mode
// - pcm request pins of attached channels
// - strobe two on parallel bit seven, isdn modes
// - clear-to-send change sets event, plain mode, optional abort
// - request pin function per mode
// - inverted generator clock, high when disabled
module spm_pin_mux
  import spm_pkg::*;
#(
  parameter int unsigned PORT2_PINS = 8,
  parameter int unsigned PORT3_PIO  = 5
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [31:0]           wb_dat_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic                  wb_we_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  receive_data_pin_i,
  output logic                       transmit_data_pin_o,
  output logic                       transmit_data_pin_oe_n,
  input  wire logic                  receive_clock_pin_i,
  output logic                       receive_clock_pin_o,
  output logic                       receive_clock_pin_oe_n,
  input  wire logic                  transmit_clock_pin_i,
  output logic                       transmit_clock_pin_o,
  output logic                       transmit_clock_pin_oe_n,
  input  wire logic                  carrier_detect_pin_i,
  input  wire logic                  clear_to_send_pin_i,
  output logic                       clear_to_send_pin_o,
  output logic                       clear_to_send_pin_oe_n,
  output logic                       request_to_send_pin_o,
  output logic                       baud_gen_clock_out_o,
  output logic [PORT2_PINS-1:0]      port2_pin_o,
  output logic [PORT3_PIO+2:0]       port3_pin_o,
  input  wire logic                  baud_gen_clk_i,
  input  wire logic                  isdn_data_clk_i,
  input  wire logic                  isdn_b1_time_i,
  input  wire logic                  isdn_b2_time_i,
  input  spm_pkg::spm_chan_t         ch_txd_i,
  input  spm_pkg::spm_chan_t         ch_rts_i,
  input  wire logic [PORT2_PINS-1:0] ch2_pin_i,
  input  wire logic [PORT3_PIO+2:0]  ch3_pin_i,
  input  wire logic [PORT2_PINS-1:0] pio2_pin_i,
  input  wire logic [PORT3_PIO-1:0]  pio3_pin_i,
  input  wire logic [2:0]            scp_pin_i,
  output spm_pkg::spm_chan_t         ch_rxd_o,
  output logic                       ch1_rx_clk_o,
  output logic                       ch1_tx_clk_o,
  output logic                       ch1_cd_o,
  output logic                       ch1_cts_o,
  output logic                       ch1_sync_o,
  output logic                       ext_irq_o,
  output logic                       cts_abort_o
);
  import spm_pkg::*;

  localparam int unsigned NSYNC = 5; // rxd, rclk, tclk, cd, cts

  // byte-lane merge used by the mode, clock control, slot map and port select registers
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // three-stage pin synchronisers; a change counts once stages two and three agree
  logic [NSYNC-1:0] s1_q, s2_q, s3_q, pin_q, pin_d;
  always_comb begin
    pin_d = pin_q;
    for (int i = 0; i < NSYNC; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        pin_d[i] = s3_q[i];
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q  <= 5'h1F;
      s2_q  <= 5'h1F;
      s3_q  <= 5'h1F;
      pin_q <= 5'h1F;
    end else begin
      s1_q  <= {clear_to_send_pin_i, carrier_detect_pin_i, transmit_clock_pin_i,
                receive_clock_pin_i, receive_data_pin_i};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= pin_d;
    end
  end
  logic rxd_s, rclk_s, tclk_s, cd_s, cts_s;
  assign {cts_s, cd_s, tclk_s, rclk_s, rxd_s} = pin_q;

  // register file and wishbone slave; ack one cycle after the request, then low
  logic [31:0] mode_q, mode_d, clk_q, clk_d, slot_q, slot_d, psel_q, psel_d;
  logic [1:0]  ev_q, ev_d, ev_set;
  logic [31:0] rdat_q, rdat_d;
  logic        ack_q, ack_d, wr_en;
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;

  spm_mode_t mode;
  logic      non_multiplexed_mode, pcm, isdn, int_brg;
  assign mode    = spm_mode_t'(mode_q[`SPM_MODE_SEL_LSB +: 2]);
  assign non_multiplexed_mode    = (mode == SPM_NON_MULTIPLEXED_MODE);
  assign pcm     = (mode == SPM_PCM_MODE);
  assign isdn    = ~non_multiplexed_mode & ~pcm;
  assign int_brg = mode_q[`SPM_MODE_INT_BRG];

  always_comb begin
    mode_d = mode_q;
    clk_d  = clk_q;
    slot_d = slot_q;
    psel_d = psel_q;
    ev_d   = ev_q;
    rdat_d = 32'h0000_0000;
    ack_d  = wb_cyc_i & wb_stb_i & ~ack_q;
    if (wr_en) begin
      case (wb_adr_i)
        `SPM_ADDR_MODE:    mode_d = lane_merge(mode_q, wb_dat_i, wb_sel_i);
        `SPM_ADDR_CLKCTL:  clk_d  = lane_merge(clk_q, wb_dat_i, wb_sel_i);
        `SPM_ADDR_SLOTMAP: slot_d = lane_merge(slot_q, wb_dat_i, wb_sel_i);
        `SPM_ADDR_PORTSEL: psel_d = lane_merge(psel_q, wb_dat_i, wb_sel_i);
        `SPM_ADDR_EVENT: begin
          if (wb_sel_i[0]) begin
            ev_d = ev_q & ~wb_dat_i[1:0]; // write one to clear
          end
        end
        default: ;
      endcase
    end
    ev_d = ev_d | ev_set; // a new event beats a clear in the same cycle
    if (wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_q) begin
      case (wb_adr_i)
        `SPM_ADDR_MODE:    rdat_d = mode_q;
        `SPM_ADDR_CLKCTL:  rdat_d = clk_q;
        `SPM_ADDR_SLOTMAP: rdat_d = slot_q;
        `SPM_ADDR_PORTSEL: rdat_d = psel_q;
        `SPM_ADDR_EVENT:   rdat_d = {30'h0000_0000, ev_q};
        `SPM_ADDR_STATUS:  rdat_d = {28'h000_0000, mode, cts_s, cd_s};
        default:           rdat_d = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= `SPM_MODE_RESET;
      clk_q  <= `SPM_CLKCTL_RESET;
      slot_q <= `SPM_SLOTMAP_RESET;
      psel_q <= `SPM_PORTSEL_RESET;
      ev_q   <= 2'h0;
      rdat_q <= 32'h0000_0000;
      ack_q  <= 1'b0;
    end else begin
      mode_q <= mode_d;
      clk_q  <= clk_d;
      slot_q <= slot_d;
      psel_q <= psel_d;
      ev_q   <= ev_d;
      rdat_q <= rdat_d;
      ack_q  <= ack_d;
    end
  end
  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;

  // line change filters: carrier on the receive clock, clear-to-send on the transmit clock
  logic [1:0] lclk_prev_q, lclk_prev_d, lvl_q, lvl_d, lclk, line;
  logic [3:0] cnt_q, cnt_d;
  assign lclk = {(non_multiplexed_mode & int_brg) ? baud_gen_clk_i : tclk_s,
                 (non_multiplexed_mode & int_brg) ? baud_gen_clk_i : rclk_s};
  assign line = {cts_s, cd_s};
  always_comb begin
    lclk_prev_d = lclk;
    lvl_d       = lvl_q;
    cnt_d       = cnt_q;
    ev_set      = 2'h0;
    for (int i = 0; i < 2; i++) begin
      if (line[i] == lvl_q[i]) begin
        cnt_d[2*i +: 2] = 2'h0;
      end else if (lclk[i] & ~lclk_prev_q[i]) begin
        if (cnt_q[2*i +: 2] + 2'h1 >= `SPM_HOLD_EDGES) begin
          lvl_d[i]        = line[i];
          cnt_d[2*i +: 2] = 2'h0;
          ev_set[i]       = non_multiplexed_mode;
        end else begin
          cnt_d[2*i +: 2] = cnt_q[2*i +: 2] + 2'h1;
        end
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lclk_prev_q <= 2'h3;
      lvl_q       <= 2'h3;
      cnt_q       <= 4'h0;
    end else begin
      lclk_prev_q <= lclk_prev_d;
      lvl_q       <= lvl_d;
      cnt_q       <= cnt_d;
    end
  end

  // pin and channel routing, all registered so every output leaves a flop
  logic        txd_d, txd_oe_n_d, rclk_d, rclk_oe_n_d, tclk_d, tclk_oe_n_d;
  logic        cts_o_d, cts_oe_n_d, rts_d, brg_d, rxclk_d, txclk_d, cd_d, ctsc_d, sync_d, irq_d, abort_d;
  logic        data_strobe_output_1, data_strobe_output_2, slot_on;
  logic [1:0]  code, slot_ch;
  spm_chan_t   rxd_d, attached;
  logic [PORT2_PINS-1:0] p2_d;
  logic [PORT3_PIO+2:0]  p3_d;
  logic [31:0] q_txd, q_rclk, q_tclk, q_cts, q_rts, q_brg, q_misc;

  assign code    = {cd_s, tclk_s};
  assign slot_on = (code != 2'h0);
  assign slot_ch = slot_q[`SPM_SLOT_W*2'(code - 2'h1) +: 2];
  assign data_strobe_output_1 = (slot_q[`SPM_DATA_STROBE_OUTPUT_1_LSB] & isdn_b1_time_i) | (slot_q[`SPM_DATA_STROBE_OUTPUT_1_LSB+1] & isdn_b2_time_i);
  assign data_strobe_output_2 = (slot_q[`SPM_DATA_STROBE_OUTPUT_2_LSB] & isdn_b1_time_i) | (slot_q[`SPM_DATA_STROBE_OUTPUT_2_LSB+1] & isdn_b2_time_i);

  // a channel is on the highway if any slot names it
  generate
    for (genvar c = 0; c < 3; c++) begin : g_att
      assign attached[c] = (slot_q[1:0] == 2'(c)) | (slot_q[3:2] == 2'(c)) | (slot_q[5:4] == 2'(c));
    end
  endgenerate

  always_comb begin
    // transmit data: plain mode push-pull or open-drain; layer-1 per mode
    txd_d      = ch_txd_i[0];
    txd_oe_n_d = 1'b0;
    if (non_multiplexed_mode) begin
      if (mode_q[`SPM_MODE_TXD_OD]) begin
        txd_d      = 1'b0;
        txd_oe_n_d = ch_txd_i[0];
      end
    end else if (pcm) begin
      txd_d      = (slot_on && slot_ch != `SPM_SLOT_NONE) ? ch_txd_i[slot_ch] : 1'b1;
      txd_oe_n_d = ~slot_on | (slot_ch == `SPM_SLOT_NONE);
    end else if (mode == SPM_SECOND_ISDN_BUS_MODE) begin
      txd_d      = 1'b0;
      txd_oe_n_d = &ch_txd_i;
    end else begin
      txd_d      = &ch_txd_i;
    end
    // receive data to the channels
    rxd_d = 3'h7;
    if (non_multiplexed_mode) begin
      rxd_d[0] = rxd_s;
    end else if (pcm) begin
      if (slot_on && slot_ch != `SPM_SLOT_NONE) begin
        rxd_d[slot_ch] = rxd_s;
      end
    end else begin
      rxd_d = {3{rxd_s}};
    end
    // clock pins; the generator drives both only in plain mode
    rclk_d      = baud_gen_clk_i;
    rclk_oe_n_d = ~(non_multiplexed_mode & int_brg) | clk_q[`SPM_CLK_RCLK_DIS];
    tclk_d      = isdn ? data_strobe_output_1 : baud_gen_clk_i;
    tclk_oe_n_d = ~((non_multiplexed_mode & int_brg) | isdn) | clk_q[`SPM_CLK_TCLK_DIS];
    rxclk_d     = (non_multiplexed_mode & int_brg) ? baud_gen_clk_i : rclk_s;
    txclk_d     = (non_multiplexed_mode & int_brg) ? baud_gen_clk_i : (non_multiplexed_mode ? tclk_s : rclk_s);
    brg_d       = clk_q[`SPM_CLK_BRG_DIS] | ~baud_gen_clk_i;
    // carrier, clear-to-send and request pins
    cd_d    = non_multiplexed_mode ? cd_s : 1'b1;
    sync_d  = non_multiplexed_mode ? (mode_q[`SPM_MODE_CD_SYNC] & cd_s) : (isdn & cd_s);
    irq_d   = non_multiplexed_mode & ~mode_q[`SPM_MODE_CD_AUTO] & ev_set[`SPM_EV_CD];
    abort_d = mode_q[`SPM_MODE_CTS_ABORT] & mode_q[`SPM_MODE_CTS_AUTO] & ev_set[`SPM_EV_CTS];
    ctsc_d     = cts_s;
    cts_o_d    = ~(slot_on & attached[0]);
    cts_oe_n_d = ~pcm;
    case (mode)
      SPM_NON_MULTIPLEXED_MODE: rts_d = ch_rts_i[0];
      SPM_FIRST_ISDN_BUS_MODE:  rts_d = &ch_rts_i;
      SPM_SECOND_ISDN_BUS_MODE: rts_d = isdn_data_clk_i;
      SPM_PCM_MODE:             rts_d = ch_rts_i[0] | ~attached[0];
      default:                  rts_d = 1'b1;
    endcase
    // port 2: channel or parallel per pin, bit seven carries strobe two in isdn
    for (int i = 0; i < PORT2_PINS; i++) begin
      p2_d[i] = psel_q[i] ? pio2_pin_i[i] : ch2_pin_i[i];
    end
    if (pcm && !psel_q[`SPM_P2_RTS_BIT]) begin
      p2_d[`SPM_P2_RTS_BIT] = ch_rts_i[1] | ~attached[1];
    end
    if (isdn) begin
      p2_d[PORT2_PINS-1] = data_strobe_output_2;
    end
    // port 3: five parallel-or-channel pins, three scp-or-channel pins
    for (int i = 0; i < PORT3_PIO; i++) begin
      p3_d[i] = psel_q[`SPM_P3_PIO_LSB+i] ? pio3_pin_i[i] : ch3_pin_i[i];
    end
    for (int i = 0; i < 3; i++) begin
      p3_d[PORT3_PIO+i] = psel_q[`SPM_SCP_EN] ? scp_pin_i[i] : ch3_pin_i[PORT3_PIO+i];
    end
    if (pcm && !psel_q[`SPM_SCP_EN]) begin
      p3_d[`SPM_P3_RTS_BIT] = ch_rts_i[2] | ~attached[2];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_txd  <= 32'h0000_0003;
      q_rclk <= 32'h0000_0002;
      q_tclk <= 32'h0000_0002;
      q_cts  <= 32'h0000_0003;
      q_rts  <= 32'h0000_0001;
      q_brg  <= 32'h0000_0001;
      q_misc <= 32'h0000_0017;
      port2_pin_o <= '0;
      port3_pin_o <= '0;
      ch_rxd_o    <= 3'h7;
    end else begin
      q_txd  <= {30'h0000_0000, txd_oe_n_d, txd_d};
      q_rclk <= {30'h0000_0000, rclk_oe_n_d, rclk_d};
      q_tclk <= {30'h0000_0000, tclk_oe_n_d, tclk_d};
      q_cts  <= {30'h0000_0000, cts_oe_n_d, cts_o_d};
      q_rts  <= {31'h0000_0000, rts_d};
      q_brg  <= {31'h0000_0000, brg_d};
      q_misc <= {24'h00_0000, 1'b0, abort_d, irq_d, sync_d, ctsc_d, cd_d, txclk_d, rxclk_d};
      port2_pin_o <= p2_d;
      port3_pin_o <= p3_d;
      ch_rxd_o    <= rxd_d;
    end
  end
  assign {transmit_data_pin_oe_n, transmit_data_pin_o}   = q_txd[1:0];
  assign {receive_clock_pin_oe_n, receive_clock_pin_o}   = q_rclk[1:0];
  assign {transmit_clock_pin_oe_n, transmit_clock_pin_o} = q_tclk[1:0];
  assign {clear_to_send_pin_oe_n, clear_to_send_pin_o}   = q_cts[1:0];
  assign request_to_send_pin_o = q_rts[0];
  assign baud_gen_clock_out_o  = q_brg[0];
  assign {cts_abort_o, ext_irq_o, ch1_sync_o, ch1_cts_o, ch1_cd_o, ch1_tx_clk_o, ch1_rx_clk_o} = q_misc[6:0];

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  bus_ack_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  brg_off_a: assert property (clk_q[`SPM_CLK_BRG_DIS] |=> baud_gen_clock_out_o) else $error("brg pin not high");
  rclk_float_a: assert property (clk_q[`SPM_CLK_RCLK_DIS] |=> receive_clock_pin_oe_n) else $error("rclk driven");
  tclk_float_a: assert property (clk_q[`SPM_CLK_TCLK_DIS] |=> transmit_clock_pin_oe_n) else $error("tclk driven");
  pcm_mute_a: assert property (pcm && code == 2'h0 |=> transmit_data_pin_oe_n && ch_rxd_o == 3'h7)
    else $error("pcm idle code not muted");
  gci_od_a: assert property (mode == SPM_SECOND_ISDN_BUS_MODE |=> !transmit_data_pin_o)
    else $error("open-drain pin driven high");
  cd_event_a: assert property (ev_set[`SPM_EV_CD] |=> ev_q[`SPM_EV_CD] && $past(cd_s) != $past(lvl_q[0], 2))
    else $error("carrier event lost");
  strobe_two_a: assert property (isdn |=> port2_pin_o[PORT2_PINS-1] == $past(data_strobe_output_2)) else $error("strobe two wrong");
  rxd_plain_a: assert property (non_multiplexed_mode |=> ch_rxd_o[0] == $past(rxd_s)) else $error("receive data not routed");
endmodule // spm_pin_mux

/* tb/spm_line_model.sv */
/*
  Line transceiver model on the far side of the serial pin mux.
  Assumes the bench clock; it resolves the two-way clock pins itself.
*/
module spm_line_model (
  input  wire logic       clk,
  input  wire logic       clk_run,
  input  wire logic       pcm,
  input  wire logic [1:0] sync,
  input  wire logic       cd_lvl,
  input  wire logic       rclk_o,
  input  wire logic       rclk_oe_n,
  input  wire logic       tclk_o,
  input  wire logic       tclk_oe_n,
  output logic            rclk_pin,
  output logic            tclk_pin,
  output logic            cd_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_q = 2'h0;
  // line clock runs only while a frame is on, else it stands still
  always @(posedge clk) begin
    if (clk_run) div_q <= div_q + 2'h1;
  end
  // the model drives a clock pin only while the device releases it
  assign rclk_pin = rclk_oe_n ? div_q[1] : rclk_o;
  assign tclk_pin = !tclk_oe_n ? tclk_o : (pcm ? sync[0] : div_q[1]);
  assign cd_pin   = pcm ? sync[1] : cd_lvl;
endmodule // spm_line_model

/* tb/test_serial_phy_pin_mux.sv */
/*
  Self-checking bench of the serial pin mux with a line partner.
  Assumes spm_pkg, spm_regs.svh and the line model are compiled first.
*/
`include "spm_regs.svh"
module test_serial_phy_pin_mux;
  timeunit 1ns;
  timeprecision 1ns;
  import spm_pkg::*;
  logic clk = 0, rst = 1, we = 0, cyc = 0, stb = 0, rxd = 1, cts = 1, bgc = 0, b1 = 0, b2 = 0;
  logic run = 0, pcm = 0, cd = 1;
  logic [1:0] sy = 2'h0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00, rnd = 8'h51, ch2 = 8'h00, pio2 = 8'h00, ch3 = 8'h00;
  logic [31:0] dat = 32'h0000_0000, rd;
  spm_chan_t ctx = 3'h7;
  logic [31:0] wdo;
  logic [7:0] p2o, p3o, ps, qs;
  spm_chan_t rxo;
  logic ack, txo, txoe, rco, rcoe, tco, tcoe, brg, irq, rcp, tcp, cdp, abt, cto, ctoe, rts;
  int fail_count = 0, tests_run = 0, irq_n = 0, abt_n = 0;
  always #50 clk = ~clk;
  spm_pin_mux uut (.clk(clk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(wdo), .wb_ack_o(ack), .receive_data_pin_i(rxd),
    .transmit_data_pin_o(txo), .transmit_data_pin_oe_n(txoe), .receive_clock_pin_i(rcp),
    .receive_clock_pin_o(rco), .receive_clock_pin_oe_n(rcoe), .transmit_clock_pin_i(tcp),
    .transmit_clock_pin_o(tco), .transmit_clock_pin_oe_n(tcoe), .carrier_detect_pin_i(cdp),
    .clear_to_send_pin_i(cts), .clear_to_send_pin_o(cto), .clear_to_send_pin_oe_n(ctoe),
    .request_to_send_pin_o(rts), .baud_gen_clock_out_o(brg), .port2_pin_o(p2o), .port3_pin_o(p3o),
    .baud_gen_clk_i(bgc), .isdn_data_clk_i(bgc), .isdn_b1_time_i(b1), .isdn_b2_time_i(b2), .ch_txd_i(ctx),
    .ch_rts_i(ctx), .ch2_pin_i(ch2), .ch3_pin_i(ch3), .pio2_pin_i(pio2), .pio3_pin_i(pio2[4:0]),
    .scp_pin_i(pio2[7:5]), .ch_rxd_o(rxo), .ch1_rx_clk_o(), .ch1_tx_clk_o(), .ch1_cd_o(), .ch1_cts_o(),
    .ch1_sync_o(), .ext_irq_o(irq), .cts_abort_o(abt));
  spm_line_model line (.clk(clk), .clk_run(run), .pcm(pcm), .sync(sy), .cd_lvl(cd), .rclk_o(rco),
    .rclk_oe_n(rcoe), .tclk_o(tco), .tclk_oe_n(tcoe), .rclk_pin(rcp), .tclk_pin(tcp), .cd_pin(cdp));
  // pulse counters for the carrier interrupt and the clear-to-send abort
  always @(posedge clk) begin
    if (irq === 1'b1) irq_n++;
    if (abt === 1'b1) abt_n++;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // expected port pin: parallel where selected, channel otherwise
  function automatic logic [7:0] port_exp(input logic [7:0] s, input logic [7:0] p, input logic [7:0] c);
    return (s & p) | (~s & c);
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  // one classic cycle: held until ack is sampled high, then released
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    adr <= a; we <= w; dat <= d; sel <= 4'hf; cyc <= 1; stb <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (ack !== 1'b1) begin
      fail_count++;
      finish_test();
    end
    rd = wdo;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(a, 0, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic w8(input int n);
    repeat (n) @(posedge clk);
  endtask
  initial begin
    w8(20);
    rst <= 0;
    rdc("mode", `SPM_ADDR_MODE, `SPM_MODE_RESET);
    rdc("slotmap", `SPM_ADDR_SLOTMAP, `SPM_SLOTMAP_RESET);
    rdc("clkctl", `SPM_ADDR_CLKCTL, `SPM_CLKCTL_RESET);
    rdc("unmapped", 8'h20, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wb(`SPM_ADDR_MODE, 1, 32'h0000_0030 | m);
      wb(`SPM_ADDR_STATUS, 0, 32'h0);
      chk("status mode", m, rd[3:2]);
    end
    wb(`SPM_ADDR_MODE, 1, 32'h0000_0030);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      ps = rnd;
      rnd = lfsr(rnd);
      qs = {{3{rnd[7]}}, rnd[4:0]};
      wb(`SPM_ADDR_PORTSEL, 1, {15'h0, qs[7], 3'h0, qs[4:0], ps});
      rnd = lfsr(rnd);
      pio2 <= rnd; ch3 <= ~rnd;
      rnd = lfsr(rnd);
      ch2 <= rnd;
      w8(3);
      chk("port2", port_exp(ps, pio2, ch2), p2o);
      chk("port3", port_exp(qs, pio2, ch3), p3o);
      rdc("portsel", `SPM_ADDR_PORTSEL, {15'h0, qs[7], 3'h0, qs[4:0], ps});
    end
    run <= 1; rxd <= 0; cd <= 0;
    w8(30);
    chk("ch1 rxd", 0, rxo[0]);
    chk("rclk dir ext", 1, rcoe);
    rdc("status cd", `SPM_ADDR_STATUS, 32'h2);
    rdc("event cd", `SPM_ADDR_EVENT, 32'h1);
    wb(`SPM_ADDR_EVENT, 1, 32'h1);
    rdc("event clr", `SPM_ADDR_EVENT, 32'h0);
    wb(`SPM_ADDR_MODE, 1, 32'h0000_0020);
    irq_n = 0;
    cd <= 1;
    w8(30);
    chk("cd irq", 1, irq_n);
    wb(`SPM_ADDR_MODE, 1, 32'h0000_0060);
    cts <= 0;
    w8(30);
    chk("cts abort", 1, abt_n);
    rdc("event cts", `SPM_ADDR_EVENT, 32'h3);
    wb(`SPM_ADDR_CLKCTL, 1, 32'h0000_3000);
    wb(`SPM_ADDR_MODE, 1, 32'h0000_0028);
    w8(3);
    chk("rclk off", 1, rcoe);
    chk("tclk off", 1, tcoe);
    wb(`SPM_ADDR_CLKCTL, 1, 32'h0);
    for (int v = 0; v < 2; v++) begin
      bgc <= v;
      w8(3);
      chk("rclk brg", {v[0], 1'b0}, {rco, rcoe});
      chk("tclk brg", {v[0], 1'b0}, {tco, tcoe});
      chk("brg out", !v[0], brg);
    end
    wb(`SPM_ADDR_CLKCTL, 1, 32'h0000_0800);
    bgc <= 0;
    w8(3);
    chk("brg off", 1, brg);
    wb(`SPM_ADDR_MODE, 1, 32'h0000_0024);
    ctx <= 3'h6;
    w8(3);
    chk("txd od low", 2'b00, {txo, txoe});
    ctx <= 3'h7;
    w8(3);
    chk("txd od rel", 1, txoe);
    wb(`SPM_ADDR_MODE, 1, 32'h0000_0032);
    w8(3);
    chk("isdn2 rel", 1, txoe);
    chk("isdn2 dclk lo", 0, rts);
    bgc <= 1;
    w8(3);
    chk("isdn2 dclk hi", 1, rts);
    wb(`SPM_ADDR_MODE, 1, 32'h0000_0031);
    wb(`SPM_ADDR_SLOTMAP, 1, 32'h0000_0F24);
    for (int s = 0; s < 2; s++) begin
      b1 <= s;
      w8(3);
      chk("strobe2", s, p2o[7]);
      chk("strobe1", {s[0], 1'b0}, {tco, tcoe});
    end
    wb(`SPM_ADDR_MODE, 1, 32'h0000_0033);
    pcm <= 1; sy <= 2'h0;
    w8(8);
    chk("pcm mute", 1, txoe);
    sy <= 2'h1;
    w8(8);
    chk("pcm slot1 txd", 0, txoe);
    chk("pcm slot1 rxd", 3'b110, rxo);
    chk("pcm cts", 2'b00, {cto, ctoe});
    finish_test();
  end
endmodule // test_serial_phy_pin_mux
